// [dv/wsw_core_model.sv]
// core sequencer and watchdog rc oscillator model facing the sleep and wake block
// assumes one system clock; the rc oscillator is free running and unrelated to it
`timescale 1ns/1ps
module wsw_core_model #(
    parameter int PC_W = 13
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pc_step_i,
    input wire logic halt_i,
    output logic wdt_tick_o,
    output logic [PC_W-1:0] pc_o
);
    // ==========================================================
    // rc oscillator: 74 ns period, keeps running while the core sleeps
    initial begin
        wdt_tick_o = 1'b0;
        forever #37 wdt_tick_o = ~wdt_tick_o;
    end
    // ==========================================================
    // program counter; frozen while the block holds the core asleep
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pc_o <= '0;
        end else if (pc_step_i && !halt_i) begin
            pc_o <= pc_o + 1'b1;
        end
    end
endmodule : wsw_core_model

// [dv/wsw_top_bench.sv]
// self-checking bench for the watchdog, sleep and wake control block
// assumes the design, its package and defines header are compiled first
`timescale 1ns/1ps
`include "wsw_defines.svh"
module wsw_top_bench;
    import wsw_pkg::*;
    localparam int TICKS = 4;
    logic clk_i, tick, dev_rst, master_clear_pin_drv, osc_run, io_hold, int_take, push, resume, wb_ack_o;
    logic rst_i = 1'b1, fuse = 1'b0, master_clear_pin = 1'b0, ext = 1'b0, pchg = 1'b0, t0ov = 1'b0;
    logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, step = 1'b1;
    logic xtal = 1'b0, osc_done = 1'b1;
    logic [7:0] wb_adr_i = 8'h00, periph_ev = 8'h00;
    logic [3:0] wb_sel_i = 4'h1;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd, r;
    logic [12:0] pc, stack_data, vector;
    wsw_phase_t phase;
    int failures = 0, compares = 0, cycles = 0, seed = 29, n;

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    wsw_core_model #(.PC_W(13)) i_core (.clk_i(clk_i), .rst_i(rst_i), .pc_step_i(step),
        .halt_i(io_hold), .wdt_tick_o(tick), .pc_o(pc));
    wsw_top #(.WDT_TICKS(TICKS), .PC_W(13)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i),
        .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
        .wdt_tick_i(tick), .watchdog_fuse_enable_i(fuse), .crystal_mode_i(xtal),
        .osc_startup_done_i(osc_done), .master_clear_pin_i(master_clear_pin), .ext_pin_i(ext),
        .port_change_i(pchg), .timer0_overflow_i(t0ov), .periph_event_i(periph_ev),
        .pc_i(pc), .int_ack_i(1'b0), .device_reset_o(dev_rst),
        .master_clear_drive_o(master_clear_pin_drv), .osc_run_o(osc_run), .io_hold_o(io_hold),
        .phase_o(phase), .int_take_o(int_take), .stack_push_o(push),
        .stack_data_o(stack_data), .vector_o(vector), .resume_o(resume));

    // ==========================================================
    // reporting
    task automatic tally_and_finish();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    // a hang anywhere ends here rather than running on
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            tally_and_finish();
        end
    end

    // ==========================================================
    // bus cycles and waits
    task automatic wb(input logic [7:0] a, input logic we, input logic [7:0] d);
        @(posedge clk_i);
        wb_adr_i <= a;
        wb_we_i <= we;
        wb_dat_i <= {24'h0, d};
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) @(posedge clk_i);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string what);
        wb(a, 1'b0, 8'h00);
        check(rd, {24'h0, exp}, what);
    endtask : rdchk

    // which: 0 device reset, 1 resume, 2 interrupt entry; cnt is -1 when none came
    task automatic wait_for(input int which, input int lim, output int cnt);
        logic hit;
        cnt = -1;
        for (int i = 0; i < lim; i++) begin
            @(posedge clk_i);
            #1;
            hit = (which == 0) ? dev_rst : ((which == 1) ? resume : int_take);
            if (hit === 1'b1) begin
                cnt = i;
                break;
            end
        end
    endtask : wait_for

    function automatic logic [7:0] exp_pflags(input logic [7:0] ev);
        return ev & `WSW_PIR_MASK;
    endfunction : exp_pflags

    // ==========================================================
    // scenarios
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk(`WSW_ADR_INTCTL, `WSW_RST_INTCTL, "intctl reset");
        rdchk(`WSW_ADR_PINCHG, 8'h00, "pin change enables reset");
        rdchk(`WSW_ADR_PFLAGS, 8'h00, "peripheral flags reset");
        rdchk(`WSW_ADR_PENABL, 8'h00, "peripheral enables reset");
        rdchk(`WSW_ADR_OPTION, `WSW_RST_OPTION, "option reset");
        rdchk(`WSW_ADR_STATUS, 8'h03, "status reset");
        rdchk(8'h1C, 8'h00, "unmapped read");
        @(posedge clk_i);
        #1;
        r = phase;
        @(posedge clk_i);
        #1;
        check(phase, 2'(r[1:0] + 2'd1), "phase steps");
        $display("test reset values done");
        for (int k = 0; k < 4; k++) begin
            r = $random(seed);
            wb(`WSW_ADR_INTCTL, 1'b1, 8'h00);
            wb(`WSW_ADR_PFLAGS, 1'b1, 8'h00);
            @(posedge clk_i);
            periph_ev <= r[7:0];
            pchg <= r[8];
            t0ov <= r[9];
            @(posedge clk_i);
            periph_ev <= 8'h00;
            pchg <= 1'b0;
            t0ov <= 1'b0;
            rdchk(`WSW_ADR_PFLAGS, exp_pflags(r[7:0]), "peripheral flags");
            rdchk(`WSW_ADR_INTCTL, {5'h0, r[9], 1'b0, r[8]}, "intctl flags");
        end
        $display("test event flags done");
        // rising pin edge, no prescaler, so one period is TICKS oscillator ticks
        wb(`WSW_ADR_OPTION, 1'b1, 8'h40);
        fuse <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            wb(`WSW_ADR_CMD, 1'b1, 8'h01);
            wait_for(0, 8, n);
            check(n, -1, "reset despite clears");
        end
        wb(`WSW_ADR_CMD, 1'b1, 8'h01);
        wait_for(0, 100, n);
        check(n >= 18 && n <= 45, 1, "timeout period");
        check(master_clear_pin_drv, 1'b0, "master clear pin driven");
        rdchk(`WSW_ADR_STATUS, 8'h01, "status after watchdog reset");
        $display("test watchdog run done");
        wb(`WSW_ADR_CMD, 1'b1, 8'h02);
        @(posedge clk_i);
        #1;
        check({io_hold, osc_run}, 2'b10, "sleep entry outputs");
        rdchk(`WSW_ADR_STATUS, 8'h02, "status after sleep");
        wait_for(1, 100, n);
        check(n >= 0 && dev_rst === 1'b0, 1, "watchdog wake");
        check({io_hold, osc_run}, 2'b01, "running after wake");
        rdchk(`WSW_ADR_STATUS, 8'h00, "status after watchdog wake");
        wait_for(0, 100, n);
        check(n >= 12, 1, "counter cleared by wake");
        $display("test watchdog sleep done");
        // crystal mode: a watchdog wake must wait for the startup timer
        xtal <= 1'b1;
        osc_done <= 1'b0;
        wb(`WSW_ADR_CMD, 1'b1, 8'h02);
        wait_for(1, 100, n);
        check(n, -1, "resumed before startup done");
        check(io_hold, 1'b1, "held during startup");
        @(posedge clk_i);
        osc_done <= 1'b1;
        wait_for(1, 4, n);
        check(n >= 0, 1, "resume after startup");
        xtal <= 1'b0;
        $display("test crystal wake done");
        fuse <= 1'b0;
        wb(`WSW_ADR_INTCTL, 1'b1, 8'h10);
        wb(`WSW_ADR_CMD, 1'b1, 8'h02);
        wait_for(1, 200, n);
        check(n, -1, "woke with fuse clear");
        @(posedge clk_i);
        ext <= 1'b1;
        wait_for(1, 40, n);
        check(n >= 0, 1, "pin wake, global enable clear");
        wait_for(2, 30, n);
        check(n, -1, "vectored with global enable clear");
        $display("test pin wake done");
        @(posedge clk_i);
        ext <= 1'b0;
        step <= 1'b0;
        wb(`WSW_ADR_INTCTL, 1'b1, 8'h90);
        wb(`WSW_ADR_CMD, 1'b1, 8'h02);
        @(posedge clk_i);
        ext <= 1'b1;
        wait_for(1, 40, n);
        check(n >= 0, 1, "pin wake, global enable set");
        wait_for(2, 30, n);
        check(n >= 0, 1, "entry after next instruction");
        check({push, stack_data, vector}, {1'b1, pc, 13'h0004}, "entry push");
        rdchk(`WSW_ADR_INTCTL, 8'h12, "global enable on entry");
        $display("test vectored wake done");
        step <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            @(posedge clk_i);
            ext <= 1'b0;
            wb(`WSW_ADR_INTCTL, 1'b1, 8'h90);
            r = $random(seed);
            repeat (r[1:0] + 1) @(posedge clk_i);
            ext <= 1'b1;
            wait_for(2, 40, n);
            check(n >= 12 && n <= 24, 1, "entry latency");
        end
        $display("test latency done");
        wb(`WSW_ADR_INTCTL, 1'b1, 8'h00);
        wb(`WSW_ADR_CMD, 1'b1, 8'h02);
        @(posedge clk_i);
        master_clear_pin <= 1'b1;
        wait_for(0, 20, n);
        check(n >= 0, 1, "master clear wake");
        @(posedge clk_i);
        master_clear_pin <= 1'b0;
        $display("test master clear done");
        tally_and_finish();
    end
endmodule : wsw_top_bench

// [rtl/wsw_defines.svh]
// constants for the watchdog, sleep and wake control block
// assumes a 100 MHz system clock and a separate free-running watchdog rc oscillator input, synchronised inside
//
// Contract
// [RULE1] pin interrupt flag sampled at phase one
// [RULE2] interrupt entry latency three to four cycles
// [RULE3] pin flag may set from phase four to one
// [RULE4] entry saves only return address
// [RULE5] watchdog runs on its own oscillator tick
// [RULE6] timeout while running resets the device
// [RULE7] timeout while asleep wakes, no reset
// [RULE8] fuse clear keeps watchdog disabled
// [RULE9] unscaled timeout nominally 18 ms
// [RULE10] option register assigns prescaler up to 128
// [RULE11] clear or sleep resets counter and prescaler
// [RULE12] every timeout clears timeout status bit
// [RULE13] crystal wake holds watchdog until startup done
// [RULE14] sleep entry clears watchdog, sets status bits
// [RULE15] watchdog reset never drives master clear pin
// [RULE16] pin wake resets; others continue execution
// [RULE17] powerdown bit set at power-up, cleared sleeping
// [RULE18] only listed sources may wake from sleep
// [RULE19] enabled interrupt wakes regardless of global enable
// [RULE20] global enable wake runs next, then vectors
// [RULE21] pending enabled flag leaves sleep at once
// [RULE22] every wake clears the watchdog counter
// [RULE23] service clears global enable, pushes, vectors
// [RULE24] select bits give powers of two ratios
`ifndef WSW_DEFINES_SVH
`define WSW_DEFINES_SVH
// ==========================================================
// register byte addresses
`define WSW_ADR_INTCTL 8'h00
`define WSW_ADR_PINCHG 8'h04
`define WSW_ADR_PFLAGS 8'h08
`define WSW_ADR_PENABL 8'h0C
`define WSW_ADR_OPTION 8'h10
`define WSW_ADR_STATUS 8'h14
`define WSW_ADR_CMD 8'h18
// ==========================================================
// reset values
`define WSW_RST_INTCTL 8'h00
`define WSW_RST_OPTION 8'hFF
// ==========================================================
// field positions
`define WSW_IC_GIE 7
`define WSW_IC_PERIPHERAL_INT_ENABLE 6
`define WSW_IC_TIMER0_OVERFLOW_ENABLE 5
`define WSW_IC_EXTE 4
`define WSW_IC_PCHE 3
`define WSW_IC_TIMER0_OVERFLOW_FLAG 2
`define WSW_IC_EXTF 1
`define WSW_IC_PCHF 0
`define WSW_OPT_EDGE 6
`define WSW_OPT_PSA 3
`define WSW_ST_TO 1
`define WSW_ST_PD 0
`define WSW_CMD_CLR 0
`define WSW_CMD_SLEEP 1
`define WSW_PIR_MASK 8'h7B
// ==========================================================
// timing: watchdog base period in ms and its tick counts
`define WSW_WDT_MS 18
`define WSW_WDT_TICK_KHZ 31
`define WSW_WDT_TICKS (`WSW_WDT_MS * `WSW_WDT_TICK_KHZ)
`define WSW_VECTOR 13'h0004
`endif

// [rtl/wsw_pkg.sv]
// types for the watchdog, sleep and wake control block
// no assumptions beyond the defines header
package wsw_pkg;
    typedef enum logic [1:0] {
        WSW_RUN,
        WSW_SLEEP,
        WSW_HOLD
    } wsw_pwr_t;
    typedef enum logic [1:0] {
        WSW_Q1,
        WSW_Q2,
        WSW_Q3,
        WSW_Q4
    } wsw_phase_t;
endpackage : wsw_pkg

// [rtl/wsw_top.sv]
// watchdog, sleep entry, wake and interrupt entry control
// assumes the core gives clear and sleep strobes; watchdog tick comes from the rc oscillator
//
// The address map and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ps
`include "wsw_defines.svh"
module wsw_top #(
    parameter int WDT_TICKS = `WSW_WDT_TICKS,
    parameter int PC_W = 13
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    input wire logic wdt_tick_i,
    input wire logic watchdog_fuse_enable_i,
    input wire logic crystal_mode_i,
    input wire logic osc_startup_done_i,
    input wire logic master_clear_pin_i,
    input wire logic ext_pin_i,
    input wire logic port_change_i,
    input wire logic timer0_overflow_i,
    input wire logic [7:0] periph_event_i,
    input wire logic [PC_W-1:0] pc_i,
    input wire logic int_ack_i,
    output logic device_reset_o,
    output logic master_clear_drive_o,
    output logic osc_run_o,
    output logic io_hold_o,
    output wsw_pkg::wsw_phase_t phase_o,
    output logic int_take_o,
    output logic stack_push_o,
    output logic [PC_W-1:0] stack_data_o,
    output logic [PC_W-1:0] vector_o,
    output logic resume_o
);
    import wsw_pkg::*;
    // ==========================================================
    // registers
    logic [7:0] intctl_reg, pinchg_reg, pflags_reg, penabl_reg, option_reg_q;
    logic timeout_status_n_reg, powerdown_status_n_reg;
    wsw_pwr_t pwr_reg;
    wsw_phase_t phase_reg;
    logic [2:0] ext_sync_reg, tick_sync_reg;
    logic ext_last_reg, tick_last_reg;
    logic [31:0] wdt_cnt_reg;
    logic [7:0] pre_cnt_reg;
    logic [1:0] lat_cnt_reg;
    logic pend_reg, ack_reg;
    // ==========================================================
    // bus decode
    logic bus_req, wr_en, clr_cmd, sleep_cmd;
    assign bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
    assign wr_en = bus_req & wb_we_i & wb_sel_i[0];
    assign clr_cmd = wr_en & (wb_adr_i == `WSW_ADR_CMD) & wb_dat_i[`WSW_CMD_CLR];
    assign sleep_cmd = wr_en & (wb_adr_i == `WSW_ADR_CMD) & wb_dat_i[`WSW_CMD_SLEEP];
    assign wb_ack_o = ack_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            ack_reg <= bus_req;
            if (bus_req & ~wb_we_i) begin
                unique case (wb_adr_i)
                    `WSW_ADR_INTCTL: wb_dat_o <= {24'h0, intctl_reg};
                    `WSW_ADR_PINCHG: wb_dat_o <= {24'h0, pinchg_reg};
                    `WSW_ADR_PFLAGS: wb_dat_o <= {24'h0, pflags_reg};
                    `WSW_ADR_PENABL: wb_dat_o <= {24'h0, penabl_reg};
                    `WSW_ADR_OPTION: wb_dat_o <= {24'h0, option_reg_q};
                    `WSW_ADR_STATUS: wb_dat_o <= {30'h0, timeout_status_n_reg,
                                                  powerdown_status_n_reg};
                    default: wb_dat_o <= 32'h0;
                endcase
            end
        end
    end
    // ==========================================================
    // instruction phase counter
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_reg <= WSW_Q1;
        end else begin
            unique case (phase_reg)
                WSW_Q1: phase_reg <= WSW_Q2;
                WSW_Q2: phase_reg <= WSW_Q3;
                WSW_Q3: phase_reg <= WSW_Q4;
                WSW_Q4: phase_reg <= WSW_Q1;
            endcase
        end
    end
    assign phase_o = phase_reg;
    // ==========================================================
    // pin synchronisers: three flops, act when second and third agree
    logic ext_lvl, ext_edge, tick_lvl, tick_rise, edge_win;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_sync_reg <= 3'h0;
            tick_sync_reg <= 3'h0;
            ext_last_reg <= 1'b0;
            tick_last_reg <= 1'b0;
        end else begin
            ext_sync_reg <= {ext_sync_reg[1:0], ext_pin_i};
            tick_sync_reg <= {tick_sync_reg[1:0], wdt_tick_i};
            if (ext_sync_reg[1] == ext_sync_reg[2]) begin
                ext_last_reg <= ext_sync_reg[2];
            end
            if (tick_sync_reg[1] == tick_sync_reg[2]) begin
                tick_last_reg <= tick_sync_reg[2];
            end
        end
    end
    assign ext_lvl = (ext_sync_reg[1] == ext_sync_reg[2]) ? ext_sync_reg[2] : ext_last_reg;
    assign tick_lvl = (tick_sync_reg[1] == tick_sync_reg[2]) ? tick_sync_reg[2] : tick_last_reg;
    // edge select bit picks rising (1) or falling (0)
    assign ext_edge = option_reg_q[`WSW_OPT_EDGE] ? (ext_lvl & ~ext_last_reg)
                                                  : (~ext_lvl & ext_last_reg);
    assign tick_rise = tick_lvl & ~tick_last_reg;
    // the flag may only be set in the q4-q1 window; edges elsewhere wait for it
    logic ext_pend_reg;
    assign edge_win = (phase_reg == WSW_Q4) | (phase_reg == WSW_Q1); // RULE3
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_pend_reg <= 1'b0;
        end else if (edge_win) begin
            ext_pend_reg <= 1'b0;
        end else if (ext_edge) begin
            ext_pend_reg <= 1'b1;
        end
    end
    // ==========================================================
    // interrupt flags and enables; hardware set wins over software clear
    logic [7:0] ic_wmask, ic_set, pir_set;
    assign ic_set = {5'h0, timer0_overflow_i, (ext_edge | ext_pend_reg) & edge_win, // RULE3
                     port_change_i};
    assign ic_wmask = (wr_en && wb_adr_i == `WSW_ADR_INTCTL) ? 8'hFF : 8'h00;
    assign pir_set = periph_event_i & `WSW_PIR_MASK;
    logic take_int;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            intctl_reg <= `WSW_RST_INTCTL;
            pflags_reg <= 8'h00;
            penabl_reg <= 8'h00;
            pinchg_reg <= 8'h00;
            option_reg_q <= `WSW_RST_OPTION;
        end else begin
            intctl_reg <= ((intctl_reg & ~ic_wmask) | (wb_dat_i[7:0] & ic_wmask)) | ic_set;
            if (take_int) begin
                intctl_reg[`WSW_IC_GIE] <= 1'b0; // RULE23
            end
            if (wr_en && wb_adr_i == `WSW_ADR_PFLAGS) begin
                pflags_reg <= (wb_dat_i[7:0] & `WSW_PIR_MASK) | pir_set;
            end else begin
                pflags_reg <= pflags_reg | pir_set;
            end
            if (wr_en && wb_adr_i == `WSW_ADR_PENABL) begin
                penabl_reg <= wb_dat_i[7:0] & `WSW_PIR_MASK;
            end
            if (wr_en && wb_adr_i == `WSW_ADR_PINCHG) begin
                pinchg_reg <= wb_dat_i[7:0] & 8'h3F;
            end
            if (wr_en && wb_adr_i == `WSW_ADR_OPTION) begin
                option_reg_q <= wb_dat_i[7:0];
            end
        end
    end
    // ==========================================================
    // pending source: flag and individual enable, global enable ignored
    logic src_ic, src_pir, any_pend, global_int_enable;
    assign global_int_enable = intctl_reg[`WSW_IC_GIE];
    assign src_ic = (intctl_reg[`WSW_IC_TIMER0_OVERFLOW_ENABLE] & intctl_reg[`WSW_IC_TIMER0_OVERFLOW_FLAG])
                  | (intctl_reg[`WSW_IC_EXTE] & intctl_reg[`WSW_IC_EXTF])
                  | (intctl_reg[`WSW_IC_PCHE] & intctl_reg[`WSW_IC_PCHF]);
    assign src_pir = intctl_reg[`WSW_IC_PERIPHERAL_INT_ENABLE] & |(pflags_reg & penabl_reg);
    assign any_pend = src_ic | src_pir;
    // timer0 cannot run asleep, so only the listed sources wake
    logic wake_src;
    assign wake_src = (intctl_reg[`WSW_IC_EXTE] & intctl_reg[`WSW_IC_EXTF]) // RULE18
                    | (intctl_reg[`WSW_IC_PCHE] & intctl_reg[`WSW_IC_PCHF])
                    | src_pir; // RULE19
    // ==========================================================
    // power state, watchdog and status bits
    logic wdt_en, wdt_clr, pre_step, wdt_step, wdt_tmo, prescaler_assign, sleep_go, wake_int, master_clear_pin_wake;
    logic [2:0] ps_sel;
    logic [7:0] pre_lim;
    assign wdt_en = watchdog_fuse_enable_i; // RULE8
    assign prescaler_assign = option_reg_q[`WSW_OPT_PSA];
    assign ps_sel = option_reg_q[2:0];
    assign pre_lim = prescaler_assign ? 8'(8'h01 << ps_sel) : 8'h01; // RULE24 RULE10
    // a sleep with an enabled pending source and gie clear completes as a no-op
    assign sleep_go = sleep_cmd & (pwr_reg == WSW_RUN) & ~(any_pend & ~global_int_enable);
    assign wake_int = (pwr_reg == WSW_SLEEP) & wake_src; // RULE21
    assign master_clear_pin_wake = (pwr_reg == WSW_SLEEP) & master_clear_pin_i;
    assign wdt_clr = clr_cmd | sleep_go | (pwr_reg == WSW_HOLD) // RULE11 RULE13
                   | wake_int | master_clear_pin_wake; // RULE22
    assign pre_step = wdt_en & tick_rise; // RULE5
    assign wdt_step = pre_step & (pre_cnt_reg == pre_lim - 8'h01);
    assign wdt_tmo = wdt_step & (wdt_cnt_reg == 32'(WDT_TICKS - 1)) & ~wdt_clr; // RULE9
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wdt_cnt_reg <= 32'h0;
            pre_cnt_reg <= 8'h0;
        end else if (wdt_clr | ~wdt_en | wdt_tmo) begin
            wdt_cnt_reg <= 32'h0;
            pre_cnt_reg <= 8'h0;
        end else if (pre_step) begin
            pre_cnt_reg <= wdt_step ? 8'h0 : pre_cnt_reg + 8'h01;
            if (wdt_step) begin
                wdt_cnt_reg <= wdt_cnt_reg + 32'h1;
            end
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwr_reg <= WSW_RUN;
            timeout_status_n_reg <= 1'b1;
            powerdown_status_n_reg <= 1'b1; // RULE17
            device_reset_o <= 1'b0;
            resume_o <= 1'b0;
        end else begin
            device_reset_o <= 1'b0;
            resume_o <= 1'b0;
            unique case (pwr_reg)
                WSW_RUN: begin
                    if (wdt_tmo) begin
                        device_reset_o <= 1'b1; // RULE6
                        timeout_status_n_reg <= 1'b0; // RULE12
                    end else if (sleep_go) begin
                        pwr_reg <= WSW_SLEEP;
                        powerdown_status_n_reg <= 1'b0; // RULE14 RULE17
                        timeout_status_n_reg <= 1'b1; // RULE14
                    end
                end
                WSW_SLEEP: begin
                    if (master_clear_pin_wake) begin
                        pwr_reg <= WSW_RUN;
                        device_reset_o <= 1'b1; // RULE16
                    end else if (wdt_tmo | wake_int) begin
                        if (wdt_tmo) begin
                            timeout_status_n_reg <= 1'b0; // RULE7 RULE12
                        end
                        pwr_reg <= crystal_mode_i ? WSW_HOLD : WSW_RUN;
                        resume_o <= ~crystal_mode_i; // RULE16
                    end
                end
                WSW_HOLD: begin
                    if (osc_startup_done_i) begin
                        pwr_reg <= WSW_RUN;
                        resume_o <= 1'b1; // RULE13
                    end
                end
            endcase
        end
    end
    assign master_clear_drive_o = 1'b0; // RULE15
    assign osc_run_o = (pwr_reg == WSW_RUN); // RULE14
    assign io_hold_o = (pwr_reg != WSW_RUN); // RULE14
    // ==========================================================
    // interrupt entry: flag sampled at q1, taken at the third q1 after, twelve clocks later
    logic samp;
    assign samp = (phase_reg == WSW_Q1) & (pwr_reg == WSW_RUN); // RULE1
    assign take_int = samp & pend_reg & (lat_cnt_reg == 2'd0) & global_int_enable;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_reg <= 1'b0;
            lat_cnt_reg <= 2'd0;
        end else if (samp) begin
            if (!pend_reg && any_pend && global_int_enable) begin
                pend_reg <= 1'b1; // RULE2 RULE20
                lat_cnt_reg <= 2'd2;
            end else if (pend_reg && lat_cnt_reg != 2'd0) begin
                lat_cnt_reg <= lat_cnt_reg - 2'd1;
            end else begin
                pend_reg <= 1'b0;
            end
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            int_take_o <= 1'b0;
            stack_push_o <= 1'b0;
            stack_data_o <= '0;
            vector_o <= '0;
        end else begin
            int_take_o <= take_int;
            stack_push_o <= take_int; // RULE4 RULE23
            if (take_int) begin
                stack_data_o <= pc_i;
                vector_o <= PC_W'(`WSW_VECTOR); // RULE23
            end
        end
    end
    // ==========================================================
    // checks
    AST_MASTER_CLEAR_PIN_QUIET: assert property (@(posedge clk_i) disable iff (rst_i)
        master_clear_drive_o == 1'b0) else $error("master clear driven"); // RULE15
    AST_RUN_TMO_RESET: assert property (@(posedge clk_i) disable iff (rst_i)
        (pwr_reg == WSW_RUN && wdt_tmo) |=> device_reset_o && !timeout_status_n_reg)
        else $error("run timeout did not reset"); // RULE6
    AST_SLEEP_TMO_WAKE: assert property (@(posedge clk_i) disable iff (rst_i)
        (pwr_reg == WSW_SLEEP && wdt_tmo && !master_clear_pin_wake) |=> !device_reset_o && pwr_reg != WSW_SLEEP)
        else $error("sleep timeout misbehaved"); // RULE7
    AST_FUSE_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
        !watchdog_fuse_enable_i |=> wdt_cnt_reg == 32'h0) else $error("watchdog ran"); // RULE8
    sequence s_sleep_in;
        sleep_go ##1 (pwr_reg == WSW_SLEEP);
    endsequence
    AST_SLEEP_ENTRY: assert property (@(posedge clk_i) disable iff (rst_i)
        s_sleep_in |-> !powerdown_status_n_reg && timeout_status_n_reg && !osc_run_o
        && wdt_cnt_reg == 32'h0) else $error("sleep entry wrong"); // RULE14
    AST_MASTER_CLEAR_PIN_WAKE: assert property (@(posedge clk_i) disable iff (rst_i)
        master_clear_pin_wake |=> device_reset_o) else $error("pin wake no reset"); // RULE16
    AST_WAKE_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
        wake_int |=> wdt_cnt_reg == 32'h0 && pre_cnt_reg == 8'h0) else $error("wake kept count"); // RULE22
    AST_HOLD_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
        (pwr_reg == WSW_HOLD) |=> wdt_cnt_reg == 32'h0) else $error("hold let count"); // RULE13
    AST_ENTRY_GIE: assert property (@(posedge clk_i) disable iff (rst_i)
        take_int |=> stack_push_o && !intctl_reg[`WSW_IC_GIE] && vector_o == PC_W'(`WSW_VECTOR))
        else $error("entry wrong"); // RULE23
    AST_LATENCY: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(pend_reg) |-> ##11 (take_int || !global_int_enable || pwr_reg != WSW_RUN))
        else $error("latency off"); // RULE2
endmodule : wsw_top
